/* File: logic/reset_power_cfg.svh */
`ifndef RESET_POWER_CFG_SVH
`define RESET_POWER_CFG_SVH

// ==========================================================
// register addresses
`define ADDR_PERIPH_RESET 8'hbd
`define ADDR_RESET_CAUSE 8'hc0
`define ADDR_LV_CONTROL 8'hcb
`define ADDR_LV_STATUS 8'hcc
`define ADDR_CLOCK_CONTROL_ONE 8'h8f
`define ADDR_POWER_CONTROL 8'h87
`define ADDR_WATCHDOG_CONTROL 8'hef

// ==========================================================
// field positions
`define BIT_POWER_ON_FLAG 0
`define BIT_WATCHDOG_FLAG 2
`define BIT_SOFTWARE_FLAG 7
`define BIT_LV_ENABLE 7
`define BIT_LV_FLAG 7
`define BIT_LOW_FREQ_SEL 0
`define BIT_DIV_SEL_LO 1
`define BIT_DIV_SEL_HI 2
`define BIT_IDLE 0
`define BIT_POWER_DOWN 1
`define BIT_WATCHDOG_RESET_EN 7
`define MASK_PERIPH_RESET 8'h0f

// ==========================================================
// reset values and timing
`define RESET_VECTOR 16'h0000
`define ZERO_BYTE 8'h00
`define RESET_HOLD_CYCLES 4'h8
`define ONE_COUNT 4'h1
`define ZERO_COUNT 4'h0
`define LS_DIV_500HZ 10'h3ff
`define LS_DIV_4K 10'h07f
`define LS_DIV_32K 10'h00f
`define LS_DIV_256K 10'h001

`endif

/* File: logic/reset_power_pkg.sv */
package reset_power_pkg;

    // power state, gray coded along normal->idle->power-down
    typedef enum logic [1:0] {
        st_normal = 2'b00,
        st_idle = 2'b01,
        st_power_down = 2'b11
    } power_state_t;

    // peripheral reset group
    typedef struct packed {
        logic serial_port;
        logic spi_unit;
        logic second_i2c;
        logic first_i2c;
    } periph_reset_t;

    // power-down wake sources
    typedef struct packed {
        logic pin_change;
        logic ext_int;
        logic i2c_addr_match;
        logic usb_resume;
        logic low_voltage;
    } wake_src_t;

endpackage

/* File: logic/reset_and_power_mode_control.sv */
`timescale 1ns/1ps
`include "reset_power_cfg.svh"
// What this block does
// - reset halts core, clears registers, vector zero
// - reset never touches data memory
// - three reset causes: power-on, watchdog, software
// - power-on holds reset, sets bit 0
// - watchdog overflow sets bit 2, resets if enabled
// - power-on clears watchdog and software flags
// - write 1 bit 7 resets; reads back 1
// - reserved cause bits read 0, ignore writes
// - per-event flag update table
// - hardware flags stay until software clears
// - four peripheral reset bits, one per unit
// - bit 7 enables detector; wakes sleep
// - low-voltage flag bit 7, writable
// - low supply resets no register; with detector on, sets flag and ends sleep
// - clock bit 0 selects low-speed clock
// - low-speed divided from 512kHz, two-bit select
// - high-speed source fixed by option
// - peripherals on system or high-speed clock
// - power bit 0 idles core until wake
// - power bit 1 enters power-down
// - watchdog enabled keeps low-speed clock running
// - listed events end power-down
module reset_and_power_mode_control
    import reset_power_pkg::*;
(
    // clock and power-on reset
    input wire logic clock,
    input wire logic rstn,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [7:0] reg_rdata,
    // events from the system
    input wire logic watchdog_overflow,
    input wire logic debug_port_reset,
    input wire logic supply_low,
    input wire logic interrupt_pending,
    input wire wake_src_t wake_in,
    input wire logic [1:0] high_speed_source_option,
    // outputs to the core and peripherals
    output logic core_reset,
    output logic core_halt,
    output logic peripheral_halt,
    output logic [15:0] start_address,
    output periph_reset_t periph_reset,
    output logic low_speed_select,
    output logic low_speed_tick,
    output logic low_speed_clock_run,
    output logic high_speed_clock_run,
    output logic [1:0] high_speed_source
);

    // ==========================================================
    // pin synchronisers
    logic [1:0] sync_wdog;
    logic [1:0] sync_dbg;
    logic [1:0] sync_low;
    logic [1:0] sync_irq;
    wake_src_t wake_meta;
    wake_src_t wake_sync;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            sync_wdog <= 2'h0;
            sync_dbg <= 2'h0;
            sync_low <= 2'h0;
            sync_irq <= 2'h0;
            wake_meta <= '0;
            wake_sync <= '0;
        end else begin
            sync_wdog <= {sync_wdog[0], watchdog_overflow};
            sync_dbg <= {sync_dbg[0], debug_port_reset};
            sync_low <= {sync_low[0], supply_low};
            sync_irq <= {sync_irq[0], interrupt_pending};
            wake_meta <= wake_in;
            wake_sync <= wake_meta;
        end
    end
    wire wdog_ovf = sync_wdog[1];
    wire dbg_rst = sync_dbg[1];
    wire low_v = sync_low[1];
    wire irq = sync_irq[1];

    // ==========================================================
    // registers
    logic power_on_flag;
    logic watchdog_reset_flag;
    logic software_reset_flag;
    logic [3:0] periph_bits;
    logic low_voltage_detector_enable;
    logic low_voltage_status_flag;
    logic [2:0] clock_control_one;
    logic watchdog_reset_enable;
    logic [1:0] power_control;
    logic [3:0] hold_count;
    logic soft_req;
    logic wdog_req;
    power_state_t state;
    power_state_t next_state;

    wire wr_cause = reg_write && reg_addr == `ADDR_RESET_CAUSE;
    wire wr_periph = reg_write && reg_addr == `ADDR_PERIPH_RESET;
    wire wr_lvc = reg_write && reg_addr == `ADDR_LV_CONTROL;
    wire wr_lvs = reg_write && reg_addr == `ADDR_LV_STATUS;
    wire wr_clk = reg_write && reg_addr == `ADDR_CLOCK_CONTROL_ONE;
    wire wr_pwr = reg_write && reg_addr == `ADDR_POWER_CONTROL;
    wire wr_wdc = reg_write && reg_addr == `ADDR_WATCHDOG_CONTROL;
    wire sw_reset_write = wr_cause && reg_wdata[`BIT_SOFTWARE_FLAG];
    wire wdog_reset_now = wdog_ovf && watchdog_reset_enable;
    wire in_reset = hold_count != `ZERO_COUNT;

    // power-on or debug-port reset: whole block to defaults
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            power_on_flag <= 1'b1;
            watchdog_reset_flag <= 1'b0;
            software_reset_flag <= 1'b0;
        end else if (dbg_rst) begin
            power_on_flag <= 1'b1;
            watchdog_reset_flag <= 1'b0;
            software_reset_flag <= 1'b0;
        end else begin
            // set wins over software clear; writing 0 to bit 7 leaves the software flag unchanged
            if (wr_cause && !reg_wdata[`BIT_POWER_ON_FLAG])
                power_on_flag <= 1'b0;
            if (wdog_ovf)
                watchdog_reset_flag <= 1'b1;
            else if (wr_cause && !reg_wdata[`BIT_WATCHDOG_FLAG])
                watchdog_reset_flag <= 1'b0;
            if (soft_req)
                software_reset_flag <= 1'b1;
            else if (wr_cause && !reg_wdata[`BIT_SOFTWARE_FLAG])
                software_reset_flag <= software_reset_flag;
        end
    end

    // pending system reset requests and hold counter
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            soft_req <= 1'b0;
            wdog_req <= 1'b0;
            hold_count <= `RESET_HOLD_CYCLES;
        end else begin
            soft_req <= sw_reset_write;
            wdog_req <= wdog_reset_now;
            if (soft_req || wdog_req || dbg_rst)
                hold_count <= `RESET_HOLD_CYCLES;
            else if (in_reset)
                hold_count <= hold_count - `ONE_COUNT;
        end
    end

    // control registers; system reset returns them to defaults
    // data memory lives outside and sees no reset from here
    // low supply alone never clears anything
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            periph_bits <= 4'h0;
            low_voltage_detector_enable <= 1'b0;
            low_voltage_status_flag <= 1'b0;
            clock_control_one <= 3'h0;
            watchdog_reset_enable <= 1'b0;
        end else if (soft_req || wdog_req || dbg_rst) begin
            periph_bits <= 4'h0;
            low_voltage_detector_enable <= 1'b0;
            low_voltage_status_flag <= 1'b0;
            clock_control_one <= 3'h0;
            watchdog_reset_enable <= 1'b0;
        end else begin
            if (wr_periph)
                periph_bits <= reg_wdata[3:0];
            if (wr_lvc)
                low_voltage_detector_enable <= reg_wdata[`BIT_LV_ENABLE];
            if (low_v && low_voltage_detector_enable)
                low_voltage_status_flag <= 1'b1;
            else if (wr_lvs)
                low_voltage_status_flag <= reg_wdata[`BIT_LV_FLAG];
            if (wr_clk)
                clock_control_one <= reg_wdata[2:0];
            if (wr_wdc)
                watchdog_reset_enable <= reg_wdata[`BIT_WATCHDOG_RESET_EN];
        end
    end

    // ==========================================================
    // power state machine
    wire wake_pd = wdog_reset_now || wake_sync.pin_change || wake_sync.ext_int
        || wake_sync.i2c_addr_match || wake_sync.usb_resume
        || (wake_sync.low_voltage && low_voltage_detector_enable)
        || (low_v && low_voltage_detector_enable);
    always_comb begin
        next_state = state;
        case (state)
            st_normal: begin
                if (wr_pwr && reg_wdata[`BIT_POWER_DOWN])
                    next_state = st_power_down;
                else if (wr_pwr && reg_wdata[`BIT_IDLE])
                    next_state = st_idle;
            end
            st_idle: begin
                if (irq || (low_v && low_voltage_detector_enable))
                    next_state = st_normal;
            end
            st_power_down: begin
                if (wake_pd)
                    next_state = st_normal;
            end
            default: next_state = st_normal;
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            state <= st_normal;
            power_control <= 2'h0;
        end else if (soft_req || wdog_req || dbg_rst) begin
            state <= st_normal; // any reset wakes
            power_control <= 2'h0;
        end else begin
            state <= next_state;
            power_control <= {next_state == st_power_down, next_state == st_idle};
        end
    end

    // ==========================================================
    // low-speed divider from the 512kHz reference tick
    logic [9:0] ls_count;
    logic [9:0] ls_limit;
    always_comb begin
        case (clock_control_one[`BIT_DIV_SEL_HI:`BIT_DIV_SEL_LO])
            2'h0: ls_limit = `LS_DIV_500HZ;
            2'h1: ls_limit = `LS_DIV_4K;
            2'h2: ls_limit = `LS_DIV_32K;
            default: ls_limit = `LS_DIV_256K;
        endcase
    end
    wire ls_run = state != st_power_down || watchdog_reset_enable;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            ls_count <= 10'h000;
            low_speed_tick <= 1'b0;
        end else if (!ls_run) begin
            ls_count <= 10'h000;
            low_speed_tick <= 1'b0;
        end else if (ls_count >= ls_limit) begin
            ls_count <= 10'h000;
            low_speed_tick <= 1'b1;
        end else begin
            ls_count <= ls_count + 10'h001;
            low_speed_tick <= 1'b0;
        end
    end

    // ==========================================================
    // registered outputs
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            core_reset <= 1'b1;
            core_halt <= 1'b1;
            peripheral_halt <= 1'b0;
            start_address <= `RESET_VECTOR;
            periph_reset <= '1;
            low_speed_select <= 1'b0;
            low_speed_clock_run <= 1'b1;
            high_speed_clock_run <= 1'b1;
            high_speed_source <= 2'h0;
        end else begin
            core_reset <= in_reset;
            core_halt <= in_reset || next_state != st_normal;
            peripheral_halt <= next_state == st_power_down;
            start_address <= `RESET_VECTOR;
            // peripherals follow core reset too
            periph_reset <= periph_reset_t'(periph_bits | {4{in_reset}});
            low_speed_select <= clock_control_one[`BIT_LOW_FREQ_SEL];
            low_speed_clock_run <= ls_run;
            high_speed_clock_run <= next_state != st_power_down
                && !clock_control_one[`BIT_LOW_FREQ_SEL];
            high_speed_source <= high_speed_source_option;
        end
    end

    // ==========================================================
    // read port; reserved bits read zero
    logic [7:0] read_mux;
    always_comb begin
        read_mux = `ZERO_BYTE;
        case (reg_addr)
            `ADDR_RESET_CAUSE: begin
                read_mux[`BIT_SOFTWARE_FLAG] = software_reset_flag;
                read_mux[`BIT_WATCHDOG_FLAG] = watchdog_reset_flag;
                read_mux[`BIT_POWER_ON_FLAG] = power_on_flag;
            end
            `ADDR_PERIPH_RESET: read_mux[3:0] = periph_bits;
            `ADDR_LV_CONTROL: read_mux[`BIT_LV_ENABLE] = low_voltage_detector_enable;
            `ADDR_LV_STATUS: read_mux[`BIT_LV_FLAG] = low_voltage_status_flag;
            `ADDR_CLOCK_CONTROL_ONE: read_mux[2:0] = clock_control_one;
            `ADDR_POWER_CONTROL: read_mux[1:0] = power_control;
            `ADDR_WATCHDOG_CONTROL:
                read_mux[`BIT_WATCHDOG_RESET_EN] = watchdog_reset_enable;
            default: read_mux = `ZERO_BYTE;
        endcase
    end
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn)
            reg_rdata <= `ZERO_BYTE;
        else if (reg_read)
            reg_rdata <= read_mux;
        else
            reg_rdata <= `ZERO_BYTE;
    end

    // ==========================================================
    // checks
    // core held in reset, cause flag up, three edges after a request
    sequence seq_held_in_reset(flag);
        ##3 core_reset && flag;
    endsequence
    AST_SOFT_RESET: assert property (@(posedge clock) disable iff (!rstn)
        sw_reset_write |-> seq_held_in_reset(software_reset_flag))
        else $error("software reset not taken");
    AST_WDOG_RESET: assert property (@(posedge clock) disable iff (!rstn)
        wdog_reset_now |-> seq_held_in_reset(watchdog_reset_flag))
        else $error("watchdog reset not taken");
    AST_WDOG_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        wdog_ovf && !dbg_rst |=> watchdog_reset_flag)
        else $error("watchdog flag not set");
    AST_DEBUG_FLAGS: assert property (@(posedge clock) disable iff (!rstn)
        dbg_rst |=> power_on_flag && !watchdog_reset_flag && !software_reset_flag)
        else $error("debug reset flags wrong");
    AST_RESERVED: assert property (@(posedge clock) disable iff (!rstn)
        reg_read && reg_addr == `ADDR_RESET_CAUSE |=> reg_rdata[6:3] == 4'h0
        && !reg_rdata[1])
        else $error("reserved cause bits not zero");
    AST_POWER_ON_STICKY: assert property (@(posedge clock) disable iff (!rstn)
        power_on_flag && !wr_cause |=> power_on_flag)
        else $error("power-on flag lost");
    AST_PERIPH_HOLD: assert property (@(posedge clock) disable iff (!rstn)
        periph_bits[0] |=> periph_reset.first_i2c)
        else $error("peripheral reset not held");
    AST_LS_RUN: assert property (@(posedge clock) disable iff (!rstn)
        state == st_power_down && watchdog_reset_enable |=> low_speed_clock_run)
        else $error("low-speed clock stopped");
    AST_PD_WAKE: assert property (@(posedge clock) disable iff (!rstn)
        state == st_power_down && wake_sync.pin_change |=> state == st_normal)
        else $error("power-down not ended");
    AST_LV_FLAG: assert property (@(posedge clock) disable iff (!rstn)
        low_v && low_voltage_detector_enable && !(soft_req || wdog_req || dbg_rst)
        |=> low_voltage_status_flag)
        else $error("low-voltage flag not set");
    AST_CLK_SEL: assert property (@(posedge clock) disable iff (!rstn)
        clock_control_one[`BIT_LOW_FREQ_SEL] |=> low_speed_select)
        else $error("clock select not followed");
    AST_HS_STOP: assert property (@(posedge clock) disable iff (!rstn)
        clock_control_one[`BIT_LOW_FREQ_SEL] |=> !high_speed_clock_run)
        else $error("high-speed clock not stopped");
    AST_IDLE_WAKE: assert property (@(posedge clock) disable iff (!rstn)
        state == st_idle && irq |=> state == st_normal)
        else $error("idle not ended by interrupt");
    AST_IDLE_HALT: assert property (@(posedge clock) disable iff (!rstn)
        state == st_idle |-> core_halt && !peripheral_halt)
        else $error("idle halt outputs wrong");
    AST_PD_HALT: assert property (@(posedge clock) disable iff (!rstn)
        state == st_power_down |-> core_halt && peripheral_halt)
        else $error("power-down halt outputs wrong");
    AST_PERIPH_IN_RESET: assert property (@(posedge clock) disable iff (!rstn)
        core_reset |-> periph_reset == 4'hf)
        else $error("peripherals free during reset");

endmodule

/* File: sim/system_side_model.sv */
`timescale 1ns/1ps
// ==========================================================
// watchdog and interrupt source facing the block
module system_side_model (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // requests from the bench
    input wire logic overflow_req,
    input wire logic irq_req,
    // core state
    input wire logic core_halt,
    // events toward the block
    output logic watchdog_overflow,
    output logic interrupt_pending
);
    logic [2:0] hold;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            hold <= 3'h0;
            watchdog_overflow <= 1'b0;
            interrupt_pending <= 1'b0;
        end else begin
            // overflow level outlasts the input synchroniser
            if (overflow_req) begin
                hold <= 3'h4;
            end else if (hold != 3'h0) begin
                hold <= hold - 3'h1;
            end
            watchdog_overflow <= overflow_req || (hold > 3'h1);
            // request stands until the core leaves halt
            if (irq_req) begin
                interrupt_pending <= 1'b1;
            end else if (!core_halt) begin
                interrupt_pending <= 1'b0;
            end
        end
    end
endmodule

/* File: sim/reset_and_power_mode_control_test.sv */
`timescale 1ns/1ps
`include "reset_power_cfg.svh"
module reset_and_power_mode_control_test;
    import reset_power_pkg::*;
    logic clock, rstn, reg_write, reg_read, supply_low, debug_port_reset;
    logic overflow_req, irq_req, watchdog_overflow, interrupt_pending, rd_due;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, d;
    logic [1:0] option, high_speed_source;
    wake_src_t wake_in;
    periph_reset_t periph_reset;
    logic core_reset, core_halt, peripheral_halt, low_speed_select, low_speed_tick;
    logic low_speed_clock_run, high_speed_clock_run;
    logic [15:0] start_address;
    logic [7:0] exp_q[$];
    logic [9:0] lim[4];
    integer seed = 24;
    int fail_count = 0;
    int cmp_count = 0;
    int cycles = 0;

    reset_and_power_mode_control reset_and_power_mode_control_i (
        .clock(clock), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .watchdog_overflow(watchdog_overflow), .debug_port_reset(debug_port_reset),
        .supply_low(supply_low), .interrupt_pending(interrupt_pending), .wake_in(wake_in),
        .high_speed_source_option(option), .core_reset(core_reset), .core_halt(core_halt),
        .peripheral_halt(peripheral_halt), .start_address(start_address),
        .periph_reset(periph_reset), .low_speed_select(low_speed_select),
        .low_speed_tick(low_speed_tick), .low_speed_clock_run(low_speed_clock_run),
        .high_speed_clock_run(high_speed_clock_run), .high_speed_source(high_speed_source));

    system_side_model system_side_model_i (
        .clock(clock), .rstn(rstn), .overflow_req(overflow_req), .irq_req(irq_req),
        .core_halt(core_halt), .watchdog_overflow(watchdog_overflow),
        .interrupt_pending(interrupt_pending));

    // ==========================================================
    // clock, compare and bus tasks
    initial begin
        clock = 1'b0;
        forever #12.5 clock = ~clock;
    end

    task automatic end_of_test;
        if (fail_count == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check(input string what, input logic [15:0] e, input logic [15:0] s);
        cmp_count++;
        if (s !== e) begin
            fail_count++;
            $display("ERROR %s expected %h seen %h", what, e, s);
        end
    endtask

    task automatic reg_wr(input logic [7:0] a, input logic [7:0] v);
        @(posedge clock);
        reg_addr <= a;
        reg_wdata <= v;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask

    task automatic reg_rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clock);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(e);
        @(posedge clock);
        reg_read <= 1'b0;
    endtask

    // sel 0 watches core_reset, 1 core_halt
    task automatic wait_lvl(input int sel, input logic lvl, input int bound);
        int n;
        n = 0;
        while (((sel == 0) ? core_reset : core_halt) !== lvl && n < bound) begin
            @(posedge clock);
            #1;
            n++;
        end
        check((sel == 0) ? "core_reset" : "core_halt", {15'h0, lvl},
              {15'h0, (sel == 0) ? core_reset : core_halt});
    endtask

    task automatic pulse(input int which);
        @(posedge clock);
        if (which == 0) overflow_req <= 1'b1;
        else irq_req <= 1'b1;
        @(posedge clock);
        overflow_req <= 1'b0;
        irq_req <= 1'b0;
    endtask

    task automatic tick_gap(input logic [1:0] sel);
        int n;
        n = 0;
        reg_wr(`ADDR_CLOCK_CONTROL_ONE, {5'h0, sel, 1'b1});
        repeat (2) @(posedge clock);
        #1;
        check("low_speed_select", 16'h1, {15'h0, low_speed_select});
        check("high_speed_clock_run", 16'h0, {15'h0, high_speed_clock_run});
        while (low_speed_tick !== 1'b1 && n < 3000) begin
            @(posedge clock);
            #1;
            n++;
        end
        n = 0;
        do begin
            @(posedge clock);
            #1;
            n++;
        end while (low_speed_tick !== 1'b1 && n < 3000);
        check("tick gap", {6'h0, lim[sel]} + 16'h1, 16'(n));
    endtask

    // ==========================================================
    // read data monitor, oldest note first
    always @(posedge clock) begin
        if (rd_due) begin
            if (exp_q.size() == 0) check("reg_rdata unexpected", 16'h0, 16'hffff);
            else check("reg_rdata", {8'h0, exp_q.pop_front()}, {8'h0, reg_rdata});
        end
        rd_due = reg_read;
    end

    always @(posedge clock) begin
        cycles++;
        if (cycles == 20000) begin
            fail_count++;
            end_of_test;
        end
    end

    // ==========================================================
    // main sequence
    initial begin
        rstn = 1'b0;
        reg_addr = 8'h00;
        reg_wdata = 8'h00;
        reg_write = 1'b0;
        reg_read = 1'b0;
        rd_due = 1'b0;
        supply_low = 1'b0;
        debug_port_reset = 1'b0;
        overflow_req = 1'b0;
        irq_req = 1'b0;
        wake_in = '0;
        option = 2'h1;
        d = 8'h00;
        lim = '{`LS_DIV_500HZ, `LS_DIV_4K, `LS_DIV_32K, `LS_DIV_256K};
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        @(posedge clock);
        #1;
        check("core_reset", 16'h1, {15'h0, core_reset});
        wait_lvl(0, 1'b0, 20);
        check("start_address", `RESET_VECTOR, start_address);
        check("periph_reset", 16'h0, {12'h0, periph_reset});
        check("high_speed_clock_run", 16'h1, {15'h0, high_speed_clock_run});
        reg_rd(`ADDR_RESET_CAUSE, 8'h01);
        reg_wr(`ADDR_RESET_CAUSE, 8'h7f);
        reg_rd(`ADDR_RESET_CAUSE, 8'h01);
        reg_wr(`ADDR_RESET_CAUSE, 8'h00);
        reg_rd(`ADDR_RESET_CAUSE, 8'h00);
        reg_rd(8'h55, 8'h00);
        for (int i = 0; i < 4; i++) begin
            d = 8'($random(seed));
            @(posedge clock);
            option <= 2'($random(seed));
            reg_wr(`ADDR_PERIPH_RESET, d);
            repeat (2) @(posedge clock);
            #1;
            check("periph_reset", {12'h0, d[3:0]}, {12'h0, periph_reset});
            check("high_speed_source", {14'h0, option}, {14'h0, high_speed_source});
            reg_rd(`ADDR_PERIPH_RESET, d & `MASK_PERIPH_RESET);
        end
        for (int s = 0; s < 4; s++) tick_gap(2'(s));
        reg_wr(`ADDR_LV_CONTROL, 8'hff);
        reg_rd(`ADDR_LV_CONTROL, 8'h80);
        @(posedge clock);
        supply_low <= 1'b1;
        repeat (4) @(posedge clock);
        supply_low <= 1'b0;
        reg_rd(`ADDR_LV_STATUS, 8'h80);
        reg_wr(`ADDR_LV_STATUS, 8'h00);
        reg_rd(`ADDR_LV_STATUS, 8'h00);
        reg_wr(`ADDR_POWER_CONTROL, 8'h01); // bus quiet after entry, as the no-op
        repeat (2) @(posedge clock);
        #1;
        check("core_halt", 16'h1, {15'h0, core_halt});
        check("peripheral_halt", 16'h0, {15'h0, peripheral_halt});
        pulse(1);
        wait_lvl(1, 1'b0, 12);
        reg_rd(`ADDR_PERIPH_RESET, d & `MASK_PERIPH_RESET);
        pulse(0);
        repeat (8) @(posedge clock);
        #1;
        check("core_reset", 16'h0, {15'h0, core_reset});
        reg_rd(`ADDR_RESET_CAUSE, 8'h04);
        reg_wr(`ADDR_WATCHDOG_CONTROL, 8'h80);
        for (int i = 0; i < 5; i++) begin
            reg_wr(`ADDR_POWER_CONTROL, 8'h02);
            repeat (2) @(posedge clock);
            #1;
            check("peripheral_halt", 16'h1, {15'h0, peripheral_halt});
            check("low_speed_clock_run", 16'h1, {15'h0, low_speed_clock_run});
            @(posedge clock);
            wake_in <= wake_src_t'(5'h1 << i);
            wait_lvl(1, 1'b0, 12);
            @(posedge clock);
            wake_in <= '0;
        end
        reg_wr(`ADDR_POWER_CONTROL, 8'h02);
        pulse(0);
        wait_lvl(0, 1'b1, 15);
        wait_lvl(0, 1'b0, 20);
        reg_rd(`ADDR_RESET_CAUSE, 8'h04);
        reg_wr(`ADDR_RESET_CAUSE, 8'h84);
        wait_lvl(0, 1'b1, 10);
        wait_lvl(0, 1'b0, 20);
        reg_rd(`ADDR_RESET_CAUSE, 8'h84);
        @(posedge clock);
        debug_port_reset <= 1'b1;
        repeat (4) @(posedge clock);
        debug_port_reset <= 1'b0;
        wait_lvl(0, 1'b1, 10);
        wait_lvl(0, 1'b0, 30);
        reg_rd(`ADDR_RESET_CAUSE, 8'h01);
        reg_wr(`ADDR_RESET_CAUSE, 8'h80);
        wait_lvl(0, 1'b1, 10);
        wait_lvl(0, 1'b0, 20);
        @(posedge clock);
        rstn <= 1'b0;
        repeat (2) @(posedge clock);
        rstn <= 1'b1;
        wait_lvl(0, 1'b0, 20);
        reg_rd(`ADDR_RESET_CAUSE, 8'h01);
        repeat (3) @(posedge clock);
        end_of_test;
    end
endmodule
